// *** spi_far_slave.sv ***
// Purpose: far-side serial slave model for the buffered port bench
// Assumes: idle-low shift clock, data changes on falling, sampled on rising
// Notes: answers each byte with the inverse of the byte it last took in
`timescale 1ns/10ps
`default_nettype none
module spi_far_slave #(
  parameter logic [7:0] FIRST = 8'h3C // reply before any byte came in
) (
  input wire logic sck, // shift clock from the master
  input wire logic mosi, // data from the master
  output logic miso, // data to the master
  output logic [7:0] got, // last whole byte taken in
  output logic [7:0] frames // whole bytes taken in
);
  logic [7:0] tx_q = FIRST; // outgoing shift register
  logic [7:0] rx_q = 8'h00; // incoming shift register
  int n = 0; // bits taken in this byte
  initial got = 8'h00;
  initial frames = 8'h00;
  assign miso = tx_q[7];
  // sample on rising edge, msb first
  always @(posedge sck) begin
    rx_q = {rx_q[6:0], mosi};
    n = n + 1;
    if (n == 8) begin
      got <= rx_q;
      frames <= frames + 8'h01;
    end
  end
  // shift out on falling edge, reload after the last bit
  always @(negedge sck) begin
    if (n == 8) begin
      tx_q <= ~rx_q;
      n = 0;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
endmodule : spi_far_slave
`default_nettype wire

// *** spi_port_buffered.sv ***
// Purpose: buffered serial port, master or slave, standard or fifo mode
// Assumes: APB slave, link pins sampled by clk_sys through two flops
// Notes: sck period is prescale product of clk_sys cycles
// Notes on behaviour
// RL1: single buffer or eight-deep fifo modes
// RL2: framed protocol, four frame configurations
// RL3: two, three or four pin operation
// RL4: software avoids read-modify-write on data
// RL5: master starts shifting once data written
// RL6: software master setup order
// RL7: software slave setup order
// RL8: slave with edge select needs select
// RL9: fifo mode select bit picks depth
// RL10: port on gives pins to port
// RL11: overflow flag set, new word dropped
// RL12: element count pending or unread words
// RL13: shifter empty flag while idle
// RL14: rx fifo empty flag
// RL15: interrupt event select field
// RL16: tx full set on write, cleared load
// RL17: rx full set on receive, cleared read
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module spi_port_buffered import spi_port_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH_DOC
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic cpu_idle, // core idle request
  input wire logic sck_in, // shift clock pin in
  output logic sck_out, // shift clock pin out
  output logic sck_oe, // shift clock drive
  input wire logic sdi_in, // serial in pin
  output logic sdo_out, // serial out pin
  output logic sdo_oe, // serial out drive
  input wire logic ss_in, // select/frame pin in
  output logic ss_out, // select/frame pin out
  output logic ss_oe, // select/frame drive
  output logic irq // level interrupt
);
  localparam int CW = $clog2(DEPTH + 1);
  // pin synchronisers
  logic sck_s1_q, sck_s2_q, sck_s3_q, sdi_s1_q, sdi_s2_q, ss_s1_q, ss_s2_q;
  // software registers
  logic port_on_q, halt_q, rov_q; // status control bits
  logic [2:0] irq_event_select_q; // interrupt event select
  logic [15:0] con1_q, con2_q; // control registers
  logic [1:0] ists_q, imsk_q; // interrupt status and mask
  // apb flops
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  // engine flops
  eng_state_e eng_q; // shift engine state
  logic [8:0] half_cnt_q; // half period counter
  logic [5:0] edge_cnt_q; // edges in word
  logic [15:0] tx_sr_q, rx_sr_q; // shifters
  logic sck_out_q, sdo_out_q, sck_oe_q, sdo_oe_q, ss_out_q, ss_oe_q;
  logic rx_push_q; // word ready for rx fifo
  logic [15:0] rx_word_q; // word to push
  // fifo wires
  logic tx_ready, tx_valid, rx_ready, rx_valid;
  logic tx_pop; // word taken by the engine
  logic [15:0] tx_data, rx_data;
  logic [CW-1:0] tx_count, rx_count, limit;
  // config decode
  logic master, ben, mode16, cke, ckp, sample_phase, select_pin_enable, frmen, fsd, fpol, fe;
  assign master = con1_q[CON1_MASTER_ROLE_SELECT];
  assign mode16 = con1_q[CON1_MODE16];
  assign cke = con1_q[CON1_CKE];
  assign ckp = con1_q[CON1_CKP];
  assign sample_phase = con1_q[CON1_SMP];
  assign select_pin_enable = con1_q[CON1_SELECT_PIN_ENABLE];
  assign ben = con2_q[CON2_BEN];
  assign frmen = con2_q[CON2_FRMEN];
  assign fsd = con2_q[CON2_FSD];
  assign fpol = con2_q[CON2_FPOL];
  assign fe = con2_q[CON2_FE];

  // two-flop pin synchronisers, third sck flop for edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
      {sdi_s1_q, sdi_s2_q, ss_s1_q, ss_s2_q} <= 4'hF;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sdi_s1_q <= sdi_in;
      sdi_s2_q <= sdi_s1_q;
      ss_s1_q <= ss_in;
      ss_s2_q <= ss_s1_q;
    end
  end

  // apb decode
  logic setup, acc, wr_en, rd_buf, wr_buf, mapped;
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr_en = acc && pwrite;
  assign wr_buf = wr_en && paddr == OFS_BUF;
  assign rd_buf = acc && !pwrite && paddr == OFS_BUF;
  assign mapped = paddr inside {OFS_STAT, OFS_CON1, OFS_CON2, OFS_BUF, OFS_ISTS, OFS_IMSK};

  // status word and read mux
  logic [15:0] stat_rd;
  logic [31:0] rd_mux;
  logic tbf, rbf, shifter_empty, halt_now;
  assign tbf = !tx_ready;
  assign rbf = rx_count >= limit;
  assign shifter_empty = eng_q == ST_IDLE;
  assign halt_now = halt_q && cpu_idle;
  always_comb begin
    stat_rd = 16'h0000;
    stat_rd[STAT_PORT_ON] = port_on_q;
    stat_rd[STAT_HALT_IDLE] = halt_q;
    // RL12 pending or unread count
    stat_rd[STAT_BEC_LO +: 3] = master ? tx_count[2:0] : rx_count[2:0];
    // RL13 shifter idle flag
    stat_rd[STAT_SHIFTER_EMPTY] = shifter_empty;
    stat_rd[STAT_ROV] = rov_q;
    // RL14 rx fifo empty
    stat_rd[STAT_RX_EMPTY] = !rx_valid;
    stat_rd[STAT_IRQ_EVENT_SELECT_LO +: 3] = irq_event_select_q;
    stat_rd[STAT_TBF] = tbf;
    stat_rd[STAT_RBF] = rbf;
    unique case (paddr)
      OFS_STAT: rd_mux = {16'h0000, stat_rd};
      OFS_CON1: rd_mux = {16'h0000, con1_q};
      OFS_CON2: rd_mux = {16'h0000, con2_q};
      OFS_BUF: rd_mux = {16'h0000, rx_data};
      OFS_ISTS: rd_mux = {30'h0, ists_q};
      OFS_IMSK: rd_mux = {30'h0, imsk_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer, ready in the access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) prdata_q <= rd_mux;
    end
  end

  // rx overflow, set wins over clear
  logic ovf_ev;
  assign ovf_ev = rx_push_q && !rx_ready;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) rov_q <= 1'b0;
    // RL11 set on dropped word
    else if (ovf_ev) rov_q <= 1'b1;
    else if (wr_en && paddr == OFS_STAT && !pwdata[STAT_ROV]) rov_q <= 1'b0;
  end

  // control register writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_on_q <= 1'b0;
      halt_q <= 1'b0;
      irq_event_select_q <= 3'h0;
      con1_q <= CON1_RST;
      con2_q <= CON2_RST;
      imsk_q <= IMSK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_STAT: begin
          port_on_q <= pwdata[STAT_PORT_ON];
          halt_q <= pwdata[STAT_HALT_IDLE];
          irq_event_select_q <= pwdata[STAT_IRQ_EVENT_SELECT_LO +: 3];
        end
        OFS_CON1: con1_q <= pwdata[15:0] & CON1_WMASK;
        OFS_CON2: con2_q <= pwdata[15:0] & CON2_WMASK;
        OFS_IMSK: imsk_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // interrupt event select
  logic evt;
  always_comb begin
    if (!ben) evt = rbf;
    else begin
      // RL15 event chosen by select field
      unique case (irq_event_select_q)
        SEL_TX_FULL: evt = tbf;
        SEL_TX_EMPTY: evt = !tx_valid && !shifter_empty;
        SEL_TX_DONE: evt = !tx_valid && shifter_empty;
        SEL_TX_SPACE: evt = tx_ready;
        SEL_RX_FULL: evt = rbf;
        SEL_RX_3Q: evt = rx_count >= CW'(RX_3Q_LEVEL);
        SEL_RX_AVAIL: evt = rx_valid;
        SEL_RX_READ: evt = !rx_valid;
      endcase
    end
  end

  // sticky interrupt status, write one clears, set wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ists_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_EVT && evt && port_on_q) || (i == IRQ_ROV && ovf_ev)) ists_q[i] <= 1'b1;
        else if (wr_en && paddr == OFS_ISTS && pwdata[i]) ists_q[i] <= 1'b0;
      end
      irq_q <= |(ists_q & imsk_q);
    end
  end

  // RL1 RL9 fifo mode picks depth
  assign limit = ben ? CW'(DEPTH) : CW'(1);
  spi_word_fifo #(.W(WORD_W), .D(DEPTH)) u_tx (
    .clk_sys(clk_sys), .reset_n(reset_n), .flush(!port_on_q), .limit(limit),
    .push_valid(wr_buf), .push_data(pwdata[15:0]), .push_ready(tx_ready),
    .pop_valid(tx_valid), .pop_ready(tx_pop), .pop_data(tx_data), .count(tx_count));
  spi_word_fifo #(.W(WORD_W), .D(DEPTH)) u_rx (
    .clk_sys(clk_sys), .reset_n(reset_n), .flush(!port_on_q), .limit(limit),
    .push_valid(rx_push_q), .push_data(rx_word_q), .push_ready(rx_ready),
    .pop_valid(rx_valid), .pop_ready(rd_buf), .pop_data(rx_data), .count(rx_count));

  // engine control terms
  logic start_word, frame_act, slave_sel, mtick, lead_ev, trail_ev, ev, done, abort;
  logic samp, chg, sample_lead;
  logic [5:0] total;
  logic [15:0] tx_shift, rx_new, load_word;
  assign total = mode16 ? 6'd32 : 6'd16;
  assign frame_act = ss_s2_q == fpol;
  // RL8 select pin gates slave
  assign slave_sel = !select_pin_enable || !ss_s2_q;
  always_comb begin
    start_word = 1'b0;
    if (port_on_q && eng_q == ST_IDLE && !halt_now) begin
      // RL5 master starts on written word
      if (master) start_word = tx_valid && (!(frmen && fsd) || frame_act);
      // RL2 framed slave waits for pulse
      else start_word = frmen ? frame_act : slave_sel;
    end
  end
  // RL16 word leaves tx buffer on load
  assign tx_pop = start_word && tx_valid;
  assign load_word = tx_valid ? tx_data : 16'h0000;
  assign abort = !master && !frmen && select_pin_enable && ss_s2_q && eng_q == ST_RUN;
  assign mtick = master && eng_q != ST_IDLE && half_cnt_q == 9'h000;
  always_comb begin
    if (master) begin
      lead_ev = mtick && eng_q == ST_RUN && sck_out_q == ckp;
      trail_ev = mtick && eng_q == ST_RUN && sck_out_q != ckp;
    end else begin
      lead_ev = eng_q == ST_RUN && sck_s2_q != sck_s3_q && sck_s3_q == ckp;
      trail_ev = eng_q == ST_RUN && sck_s2_q != sck_s3_q && sck_s3_q != ckp;
    end
  end
  assign ev = lead_ev || trail_ev;
  assign sample_lead = cke ? !(master && sample_phase) : 1'b0;
  assign samp = (lead_ev && sample_lead) || (trail_ev && !sample_lead);
  assign chg = cke ? trail_ev : (lead_ev && edge_cnt_q != 6'd0);
  assign tx_shift = {tx_sr_q[14:0], 1'b0};
  assign rx_new = samp ? {rx_sr_q[14:0], sdi_s2_q} : rx_sr_q;
  assign done = ev && edge_cnt_q == total - 6'd1;

  // msb of a word for the current width
  function automatic logic msb(input logic [15:0] w, input logic m16);
    msb = m16 ? w[15] : w[7];
  endfunction : msb

  // shift engine
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      eng_q <= ST_IDLE;
      half_cnt_q <= 9'h000;
      edge_cnt_q <= 6'd0;
      tx_sr_q <= 16'h0000;
      rx_sr_q <= 16'h0000;
      sck_out_q <= 1'b0;
      sdo_out_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= 16'h0000;
    end else begin
      rx_push_q <= 1'b0;
      if (!port_on_q || abort) begin
        eng_q <= ST_IDLE;
        edge_cnt_q <= 6'd0;
        sck_out_q <= ckp;
      end else begin
        unique case (eng_q)
          ST_IDLE: begin
            sck_out_q <= ckp;
            if (start_word) begin
              tx_sr_q <= load_word;
              sdo_out_q <= msb(load_word, mode16);
              edge_cnt_q <= 6'd0;
              half_cnt_q <= half_period(con1_q[CON1_PPRE_LO +: 2], con1_q[CON1_SPRE_LO +: 3]) - 9'h001;
              // RL2 frame pulse precedes first clock
              eng_q <= (master && frmen && !fsd && !fe) ? ST_LEAD : ST_RUN;
            end
          end
          ST_LEAD: begin
            if (mtick) begin
              edge_cnt_q <= (edge_cnt_q == 6'd1) ? 6'd0 : edge_cnt_q + 6'd1;
              if (edge_cnt_q == 6'd1) eng_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (mtick) sck_out_q <= !sck_out_q;
            rx_sr_q <= rx_new;
            if (chg) begin
              tx_sr_q <= tx_shift;
              sdo_out_q <= msb(tx_shift, mode16);
            end
            if (ev) edge_cnt_q <= edge_cnt_q + 6'd1;
            if (done) begin
              // RL17 word moves to rx buffer
              rx_push_q <= 1'b1;
              rx_word_q <= mode16 ? rx_new : {8'h00, rx_new[7:0]};
              eng_q <= ST_IDLE;
            end
          end
          default: eng_q <= ST_IDLE;
        endcase
        if (master && eng_q != ST_IDLE) begin
          half_cnt_q <= (half_cnt_q == 9'h000) ?
            half_period(con1_q[CON1_PPRE_LO +: 2], con1_q[CON1_SPRE_LO +: 3]) - 9'h001 :
            half_cnt_q - 9'h001;
        end
      end
    end
  end

  // pin ownership and frame pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {sck_oe_q, sdo_oe_q, ss_oe_q} <= 3'h0;
      ss_out_q <= 1'b1;
    end else begin
      // RL10 RL3 pins owned only when on
      sck_oe_q <= port_on_q && master && !con1_q[CON1_DISSCK];
      sdo_oe_q <= port_on_q && !con1_q[CON1_DISSDO];
      ss_oe_q <= port_on_q && frmen && !fsd;
      ss_out_q <= ((eng_q == ST_LEAD) || (fe && eng_q == ST_RUN && edge_cnt_q < 6'd2)) ? fpol : !fpol;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sck_out = sck_out_q;
  assign sck_oe = sck_oe_q;
  assign sdo_out = sdo_out_q;
  assign sdo_oe = sdo_oe_q;
  assign ss_out = ss_out_q;
  assign ss_oe = ss_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ovf_sets_flag: assert property (ovf_ev |=> rov_q && ists_q[IRQ_ROV]) // RL11
    else $error("overflow flag not set");
  a_tbf_on_write: assert property (wr_buf && !ben && tx_count == '0 && port_on_q |=> tbf) // RL16
    else $error("tx full not set on write");
  a_tbf_clr_load: assert property (tx_pop && !ben && !wr_buf |=> !tbf) // RL16
    else $error("tx full not cleared on load");
  a_rbf_clr_read: assert property (rd_buf && !ben && !rx_push_q |=> !rbf) // RL17
    else $error("rx full not cleared on read");
  a_rbf_on_recv: assert property (rx_push_q && rx_ready && port_on_q |=> rx_valid) // RL17
    else $error("received word not buffered");
  a_rx_empty_bit: assert property (setup && !pwrite && paddr == OFS_STAT // RL14
    |=> prdata[STAT_RX_EMPTY] == !$past(rx_valid))
    else $error("rx empty bit wrong");
  a_master_start: assert property (port_on_q && master && eng_q == ST_IDLE && tx_valid // RL5
    && !halt_now && !frmen |=> eng_q != ST_IDLE ##1 !shifter_empty)
    else $error("master did not start");
  a_pins_released: assert property (!port_on_q |=> !sck_oe && !sdo_oe && !ss_oe) // RL10
    else $error("pins driven while off");
  a_std_depth: assert property (!ben && $stable(ben) |-> tx_count <= CW'(1)) // RL9
    else $error("standard mode holds more than one word");
  a_word_edges: assert property (eng_q == ST_RUN |-> edge_cnt_q < total) // RL3
    else $error("edge count beyond word");
  a_irq_select: assert property (port_on_q && ben && irq_event_select_q == SEL_TX_DONE // RL15
    && !tx_valid && shifter_empty |=> ists_q[IRQ_EVT] ##1 (irq || !imsk_q[IRQ_EVT]))
    else $error("selected event lost");
  a_bec_count: assert property (setup && !pwrite && paddr == OFS_STAT && master // RL12
    |=> prdata[STAT_BEC_LO +: 3] == 3'($past(tx_count)))
    else $error("element count wrong");
  a_shifter_flag: assert property (start_word |=> !shifter_empty) // RL13
    else $error("shifter empty while loaded");
  c_master_word: cover property (master && done);
  c_slave_word: cover property (!master && done);
  c_overflow: cover property (ovf_ev);
  c_frame_lead: cover property (eng_q == ST_LEAD ##1 eng_q == ST_RUN);
endmodule : spi_port_buffered
`default_nettype wire

// *** spi_port_buffered_test.sv ***
// Purpose: self-checking bench of the buffered serial port, master role and slave select
// Assumes: one wait-free apb access cycle, byte mode, fast prescale
// Notes: read results are noted in a queue and checked by a monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module spi_port_buffered_test import spi_port_pkg::*;;
  localparam logic [7:0] FIRST_REPLY = 8'h3C; // first far-side answer
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, far_got, frames, last, b;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sck_out, sck_oe, sdo_out, sdo_oe, ss_out, ss_oe, irq, sdi;
  logic want = 1'b0; // current read is checked
  logic ss = 1'b1; // select pin level, high is deselected
  logic [15:0] rd; // last read data
  logic [7:0] e[3]; // burst replies
  logic [16:0] q_val[$], q_msk[$]; // noted results
  int num_errors = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  spi_port_buffered i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(1'b0), .sck_in(sck_out), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_in(ss), .ss_out(ss_out),
    .ss_oe(ss_oe), .irq(irq));
  spi_far_slave #(.FIRST(FIRST_REPLY)) i_far (.sck(sck_oe & sck_out),
    .mosi(sdo_oe ? sdo_out : 1'b1), .miso(sdi), .got(far_got), .frames(frames));
  // monitor: compare each checked read with the oldest note
  always @(posedge clk_sys) begin
    if (want && psel && penable && pready && q_val.size() > 0) begin
      `CHK("apb read", q_val[0] & q_msk[0], {pslverr, prdata[15:0]} & q_msk[0])
      void'(q_val.pop_front());
      void'(q_msk.pop_front());
    end
  end
  task summarize;
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task apb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic c,
           input logic [16:0] ev, input logic [16:0] m);
    int n;
    @(posedge clk_sys);
    if (c) begin
      q_val.push_back(ev);
      q_msk.push_back(m);
    end
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {16'h0000, d}; want <= c;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin num_errors++; summarize(); end
    rd = prdata[15:0];
    psel <= 1'b0; penable <= 1'b0; want <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(a, 1'b1, d, 1'b0, 17'h0, 17'h0);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [15:0] ev, input logic [15:0] m);
    apb(a, 1'b0, 16'h0000, 1'b1, {1'b0, ev}, {1'b1, m});
  endtask : rdc
  task poll(input int bi, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(OFS_STAT, 1'b0, 16'h0000, 1'b0, 17'h0, 17'h0);
      if (rd[bi] === v) return;
    end
    num_errors++; summarize();
  endtask : poll
  task send(input logic [7:0] d);
    wr(OFS_BUF, {8'h00, d});
    last = d;
  endtask : send
  initial begin
    void'($urandom(63));
    last = ~FIRST_REPLY;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(OFS_CON1, CON1_RST, 16'hFFFF);
    rdc(OFS_CON2, CON2_RST, 16'hFFFF);
    apb(8'h1C, 1'b0, 16'h0000, 1'b1, 17'h10000, 17'h1FFFF);
    `CHK("sck_oe off", 1'b0, sck_oe)
    // master role, edge select, half period of four cycles (80 ns link), then port on
    wr(OFS_CON1, 16'h013A);
    wr(OFS_STAT, 16'h8000);
    repeat (3) @(posedge clk_sys);
    `CHK("sck_oe on", 1'b1, sck_oe)
    `CHK("ss_oe unframed", 1'b0, ss_oe)
    `CHK("ss_out idle", 1'b1, ss_out)
    b = ~last; send(8'($urandom())); poll(STAT_RBF, 1'b1);
    `CHK("far byte", last, far_got)
    rdc(OFS_BUF, {8'h00, b}, 16'h00FF);
    rdc(OFS_STAT, 16'h0000, 16'h0001);
    b = ~last; send(8'($urandom())); poll(STAT_RBF, 1'b1);
    send(8'($urandom())); poll(STAT_ROV, 1'b1);
    rdc(OFS_BUF, {8'h00, b}, 16'h00FF);
    wr(OFS_IMSK, 16'h0002);
    repeat (3) @(posedge clk_sys);
    `CHK("irq set", 1'b1, irq)
    wr(OFS_ISTS, 16'h0002);
    repeat (3) @(posedge clk_sys);
    `CHK("irq clear", 1'b0, irq)
    wr(OFS_STAT, 16'h8000);
    rdc(OFS_STAT, 16'h0000, 16'h0040);
    // fifo mode: three words queued back to back, no overflow
    wr(OFS_CON2, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      e[i] = ~last;
      send(8'($urandom()));
    end
    rdc(OFS_STAT, 16'h0020, 16'h0020);
    b = frames + 8'h03;
    for (int k = 0; k < 3000 && frames != b; k++) @(posedge clk_sys);
    if (frames != b) begin num_errors++; summarize(); end
    poll(STAT_SHIFTER_EMPTY, 1'b1);
    rdc(OFS_STAT, 16'h0000, 16'h0060);
    for (int i = 0; i < 3; i++) rdc(OFS_BUF, {8'h00, e[i]}, 16'h00FF);
    rdc(OFS_STAT, 16'h0020, 16'h0020);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_STAT, 16'h8000 | 16'(s << 2));
      rdc(OFS_STAT, 16'(s << 2), 16'h001C);
    end
    // slave order: port off, buffer cleared, slave role, smp clear, port on
    wr(OFS_STAT, 16'h0000);
    wr(OFS_BUF, 16'h0000);
    // edge select set, so the select pin is enabled as well
    wr(OFS_CON1, 16'h0180);
    wr(OFS_STAT, 16'h8000);
    repeat (3) @(posedge clk_sys);
    `CHK("slave sck_oe", 1'b0, sck_oe)
    rdc(OFS_STAT, 16'h0080, 16'h0080);
    ss <= 1'b0;
    poll(STAT_SHIFTER_EMPTY, 1'b0);
    ss <= 1'b1;
    poll(STAT_SHIFTER_EMPTY, 1'b1);
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule : spi_port_buffered_test
`default_nettype wire

// *** spi_port_pkg.sv ***
// Purpose: constants, field positions and types of the buffered serial port
// Assumes: 16-bit registers placed in the low half of 32-bit APB words
// Notes: every offset and bit position lives here, with the con1, con2 and mask reset values
package spi_port_pkg;
  // register byte offsets on the APB
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_CON1 = 8'h04;
  localparam logic [7:0] OFS_CON2 = 8'h08;
  localparam logic [7:0] OFS_BUF = 8'h0C;
  localparam logic [7:0] OFS_ISTS = 8'h10;
  localparam logic [7:0] OFS_IMSK = 8'h14;
  // status/control field positions
  localparam int STAT_PORT_ON = 15;
  localparam int STAT_HALT_IDLE = 13;
  localparam int STAT_BEC_LO = 8;
  localparam int STAT_SHIFTER_EMPTY = 7;
  localparam int STAT_ROV = 6;
  localparam int STAT_RX_EMPTY = 5;
  localparam int STAT_IRQ_EVENT_SELECT_LO = 2;
  localparam int STAT_TBF = 1;
  localparam int STAT_RBF = 0;
  // control one field positions
  localparam int CON1_DISSCK = 12;
  localparam int CON1_DISSDO = 11;
  localparam int CON1_MODE16 = 10;
  localparam int CON1_SMP = 9;
  localparam int CON1_CKE = 8;
  localparam int CON1_SELECT_PIN_ENABLE = 7;
  localparam int CON1_CKP = 6;
  localparam int CON1_MASTER_ROLE_SELECT = 5;
  localparam int CON1_SPRE_LO = 2;
  localparam int CON1_PPRE_LO = 0;
  // control two field positions
  localparam int CON2_FRMEN = 15;
  localparam int CON2_FSD = 14;
  localparam int CON2_FPOL = 13;
  localparam int CON2_FE = 1;
  localparam int CON2_BEN = 0;
  // writable masks and reset values
  localparam logic [15:0] CON1_WMASK = 16'h1FFF;
  localparam logic [15:0] CON2_WMASK = 16'hE003;
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;
  localparam logic [1:0] IMSK_RST = 2'h0;
  // interrupt status bits
  localparam int IRQ_EVT = 0;
  localparam int IRQ_ROV = 1;
  // buffer sizes
  localparam int FIFO_DEPTH_DOC = 8;
  localparam int WORD_W = 16;
  localparam int RX_3Q_LEVEL = 6;
  // interrupt event select codes
  localparam logic [2:0] SEL_TX_FULL = 3'h7;
  localparam logic [2:0] SEL_TX_EMPTY = 3'h6;
  localparam logic [2:0] SEL_TX_DONE = 3'h5;
  localparam logic [2:0] SEL_TX_SPACE = 3'h4;
  localparam logic [2:0] SEL_RX_FULL = 3'h3;
  localparam logic [2:0] SEL_RX_3Q = 3'h2;
  localparam logic [2:0] SEL_RX_AVAIL = 3'h1;
  localparam logic [2:0] SEL_RX_READ = 3'h0;
  // shift engine states
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN} eng_state_e;
  // half sck period in clk_sys cycles from the two prescalers
  function automatic logic [8:0] half_period(input logic [1:0] ppre, input logic [2:0] spre);
    logic [9:0] prim;
    logic [9:0] per;
    prim = (ppre == 2'h3) ? 10'h001 : (ppre == 2'h2) ? 10'h004 :
           (ppre == 2'h1) ? 10'h010 : 10'h040;
    per = prim * (10'h008 - {7'h00, spre});
    half_period = (per < 10'h002) ? 9'h001 : per[9:1];
  endfunction : half_period
endpackage : spi_port_pkg

// *** spi_word_fifo.sv ***
// Purpose: word fifo with a run-time fill limit
// Assumes: limit never above DEPTH
// Notes: limit 1 gives the single-buffer behaviour
`timescale 1ns/10ps
`default_nettype none
module spi_word_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int CW = $clog2(D + 1)
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic flush, // empties the fifo
  input wire logic [CW-1:0] limit, // words allowed
  input wire logic push_valid, // write request
  input wire logic [W-1:0] push_data, // write word
  output logic push_ready, // room left
  output logic pop_valid, // word present
  input wire logic pop_ready, // read request
  output logic [W-1:0] pop_data, // oldest word
  output logic [CW-1:0] count // words held
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D]; // storage
  logic [AW-1:0] wr_q; // write index
  logic [AW-1:0] rd_q; // read index
  logic [CW-1:0] cnt_q; // fill level
  logic do_push; // accepted write
  logic do_pop; // accepted read

  // honest full and empty
  assign push_ready = cnt_q < limit;
  assign pop_valid = cnt_q != '0;
  assign pop_data = mem_q[rd_q];
  assign count = cnt_q;
  assign do_push = push_valid && push_ready && !flush;
  assign do_pop = pop_ready && pop_valid && !flush;

  // index wrap helper
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] i);
    nxt = (i == AW'(D - 1)) ? '0 : AW'(i + 1'b1);
  endfunction : nxt

  // pointers and level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= nxt(wr_q);
      if (do_pop) rd_q <= nxt(rd_q);
      cnt_q <= CW'(cnt_q + CW'(do_push) - CW'(do_pop));
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_push) mem_q[wr_q] <= push_data;
  end
endmodule : spi_word_fifo
`default_nettype wire
